// *** hw/ibd_modulator.sv ***
// Digital model of the isolated one-bit modulator: sample buffer, crossing and bit emitter.
//
// Summary of operation
// RULE1 - Emit one data bit per modulator clock.
// RULE2 - Ones fraction proportional to input voltage.
// RULE3 - Zero input gives fifty percent ones.
// RULE4 - Two volts gives 81.25 percent ones.
// RULE5 - Positive full scale gives all ones.
// RULE6 - Below negative full scale, stream undefined.
// RULE7 - Density equals input over 6.4 plus half.
// RULE8 - Host code scales density to 16 bits.
// RULE9 - Host codes are offset binary, 31744 to 65535.
// RULE10 - Host filter decimates bits into words.
// RULE11 - Host uses sinc3, ratio 256, 16 bits. The host model counts ones in each block instead of sinc3.
// RULE12 - Two to 3.2 volts still encoded proportionally.
// RULE13 - Drive modulator clock for capturing data.
// RULE14 - Host ignores link during start-up interval.
// RULE15 - Beyond full scale, stream is constant.
// RULE16 - Host decimator clears state, settles three periods.
// RULE17 - Host saturates result, pulses valid per word.
`default_nettype none

module ibd_modulator #(
    parameter int START_CYC = ibd_pkg::START_CYCLES,
    parameter int DEPTH     = ibd_pkg::FIFO_DEPTH
) (
    // System clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    // Modulator oscillator, twice the bit rate
    input  wire logic              i_mod_osc_clk,
    // Input samples as ideal offset-binary codes
    input  wire ibd_pkg::ibd_word_t i_word,
    input  wire logic              i_word_valid,
    output logic                   o_word_ready,
    // Status
    output logic                   o_running,
    // Link pins
    output logic                   o_mod_clk,
    output logic                   o_mod_data
);

    localparam int CW = $clog2(START_CYC + 1);
    localparam logic [CW-1:0] START_LAST = CW'(START_CYC - 1);

    // System clock domain: buffer, start-up count and the request side of the crossing.
    logic [CW-1:0]      start_cnt;
    logic               run_ref;
    ibd_pkg::ibd_hs_t   hs;
    ibd_pkg::ibd_hs_t   next_hs;
    ibd_pkg::ibd_word_t hold;
    logic               req;
    logic               ack_s;
    ibd_pkg::ibd_word_t f_data;
    logic               f_valid;
    logic               f_ready;

    ibd_fifo #(
        .W     ($bits(ibd_pkg::ibd_word_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk    (i_ref_clk),
        .i_resetn (i_resetn),
        .i_data   (i_word),
        .i_valid  (i_word_valid),
        .o_ready  (o_word_ready),
        .o_data   (f_data),
        .o_valid  (f_valid),
        .i_ready  (f_ready)
    );

    // The link stays quiet until the start-up interval has run out.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            start_cnt <= '0;
            run_ref   <= 1'b0;
        end else if (!run_ref) begin
            start_cnt <= start_cnt + CW'(1);
            run_ref   <= (start_cnt == START_LAST);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_running <= 1'b0;
        end else begin
            o_running <= run_ref;
        end
    end

    // The buffer drains only while no word is in flight, so a slow
    // modulator clock stalls the buffer and finally the source.
    assign f_ready = (hs == ibd_pkg::IBD_HS_IDLE);

    always_comb begin
        case (hs)
            ibd_pkg::IBD_HS_IDLE: next_hs = f_valid ? ibd_pkg::IBD_HS_REQ : ibd_pkg::IBD_HS_IDLE;
            ibd_pkg::IBD_HS_REQ:  next_hs = ack_s ? ibd_pkg::IBD_HS_REL : ibd_pkg::IBD_HS_REQ;
            ibd_pkg::IBD_HS_REL:  next_hs = ack_s ? ibd_pkg::IBD_HS_REL : ibd_pkg::IBD_HS_IDLE;
            default:              next_hs = ibd_pkg::IBD_HS_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            hs <= ibd_pkg::IBD_HS_IDLE;
        end else begin
            hs <= next_hs;
        end
    end

    // The held word is only rewritten in idle, so it is stable while req is high.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            hold.code <= ibd_pkg::CODE_ZERO;
        end else if (hs == ibd_pkg::IBD_HS_IDLE && f_valid) begin
            hold <= f_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            req <= 1'b0;
        end else begin
            req <= (next_hs == ibd_pkg::IBD_HS_REQ);
        end
    end

    // Modulator clock domain: from here on all runs on the oscillator except u_ack_sync and the checks clocked on i_ref_clk.
    logic [2:0]  m_sync;
    logic        mrst_n;
    logic        run_m;
    logic        req_m;
    logic        ack_m;
    logic [15:0] code;
    logic [15:0] acc;
    logic [16:0] sum;
    logic        emit;
    logic        mid_prev;

    ibd_sync #(
        .W (3)
    ) u_mod_sync (
        .i_clk (i_mod_osc_clk),
        .i_d   ({i_resetn, run_ref, req}),
        .o_q   (m_sync)
    );

    assign mrst_n = m_sync[2];
    assign run_m  = m_sync[1];
    assign req_m  = m_sync[0];

    ibd_sync #(
        .W (1)
    ) u_ack_sync (
        .i_clk (i_ref_clk),
        .i_d   (ack_m),
        .o_q   (ack_s)
    );

    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n) begin
            ack_m <= 1'b0;
        end else begin
            ack_m <= req_m;
        end
    end

    // A word is taken on the first edge that sees the request.
    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n) begin
            code <= ibd_pkg::CODE_ZERO;
        end else if (req_m && !ack_m) begin
            code <= hold.code;
        end
    end

    // The oscillator is divided by two, so each data change falls half a
    // bit period away from the capturing rising edge.
    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n || !run_m) begin
            o_mod_clk <= 1'b0;
        end else begin
            o_mod_clk <= ~o_mod_clk; // RULE13
        end
    end

    assign emit = run_m && o_mod_clk;
    assign sum  = {1'b0, acc} + {1'b0, code};

    // First-order error feedback: the carry rate equals code / 65536 exactly.
    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n || !run_m) begin
            acc        <= '0;
            o_mod_data <= 1'b0;
        end else if (emit) begin // RULE1
            if (code == ibd_pkg::FULL_SCALE_LIMIT_CODE) begin
                o_mod_data <= 1'b1; // RULE5 RULE15
            end else if (code < ibd_pkg::CODE_NEG_FULL_SCALE) begin
                o_mod_data <= 1'b0; // RULE6 RULE15
            end else begin
                acc        <= sum[15:0]; // RULE2 RULE7 RULE12
                o_mod_data <= sum[16]; // RULE3 RULE4
            end
        end
    end

    // Helper for the balance check: previous emitted bit used mid-scale code.
    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n || !run_m) begin
            mid_prev <= 1'b0;
        end else if (emit) begin
            mid_prev <= (code == ibd_pkg::CODE_ZERO);
        end
    end

    // Helpers for the window checks: each bit is counted one edge after it is emitted,
    // once it stands on the data pin, against the code that produced it.
    logic        emit_d;
    logic [15:0] code_d;
    logic [15:0] win_code;
    logic [8:0]  win_bits;
    logic [8:0]  win_ones;

    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n || !run_m) begin
            emit_d <= 1'b0;
            code_d <= ibd_pkg::CODE_ZERO;
        end else begin
            emit_d <= emit;
            code_d <= code;
        end
    end

    always_ff @(posedge i_mod_osc_clk) begin
        if (!mrst_n || !run_m) begin
            win_code <= ibd_pkg::CODE_ZERO;
            win_bits <= '0;
            win_ones <= '0;
        end else if (emit_d) begin
            if (win_bits == 9'h100 || code_d != win_code) begin
                win_code <= code_d;
                win_bits <= 9'h001;
                win_ones <= {8'h00, o_mod_data};
            end else begin
                win_bits <= win_bits + 9'h001;
                win_ones <= win_ones + {8'h00, o_mod_data};
            end
        end
    end

    // Checks on the link side and on the crossing.
    sequence s_emit;
        run_m && o_mod_clk;
    endsequence

    sequence s_in_range;
        code != ibd_pkg::FULL_SCALE_LIMIT_CODE && code >= ibd_pkg::CODE_NEG_FULL_SCALE;
    endsequence

    a_clk_toggles: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE1
        run_m && $past(run_m) |=> o_mod_clk != $past(o_mod_clk))
        else $error("Modulator clock did not toggle while running.");

    a_data_at_fall: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE13
        $changed(o_mod_data) && run_m |-> $fell(o_mod_clk))
        else $error("Data changed away from the falling clock edge.");

    a_quiet_startup: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE13
        !run_m |=> !o_mod_clk && !o_mod_data)
        else $error("Link active before start-up completed.");

    a_full_ones: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE5
        s_emit and (code == ibd_pkg::FULL_SCALE_LIMIT_CODE) |=> o_mod_data)
        else $error("Full-scale code did not emit a one.");

    a_below_zero: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE15
        s_emit and (code < ibd_pkg::CODE_NEG_FULL_SCALE) |=> !o_mod_data && $stable(acc))
        else $error("Below-range code did not emit a constant zero.");

    a_density_track: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE7
        s_emit and s_in_range |=>
            {o_mod_data, acc} == {1'b0, $past(acc)} + {1'b0, $past(code)})
        else $error("Accumulator step does not match the input code.");

    a_mid_balance: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE3
        s_emit and (code == ibd_pkg::CODE_ZERO) and mid_prev |=>
            o_mod_data != $past(o_mod_data))
        else $error("Mid-scale code did not alternate ones and zeros.");

    a_hold_stable: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // RULE2
        req |=> $stable(hold) || !$past(req))
        else $error("Held word changed while the request was up.");

    a_run_after_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // RULE13
        $rose(run_ref) |-> $past(start_cnt) == START_LAST)
        else $error("Start-up ended at the wrong count.");

    sequence s_window_full;
        win_bits == 9'h100;
    endsequence

    // Exact only for codes with a zero low byte, where 256 steps bring the accumulator back.
    a_window_density: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE7
        s_window_full and (win_code[7:0] == 8'h00)
            and (win_code >= ibd_pkg::CODE_NEG_FULL_SCALE) |-> win_ones == {1'b0, win_code[15:8]})
        else $error("Ones in a 256-bit window do not match the input code.");

    a_window_all_ones: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE15
        s_window_full and (win_code == ibd_pkg::FULL_SCALE_LIMIT_CODE) |-> win_ones == 9'h100)
        else $error("Full-scale window held a zero.");

    a_window_all_zeros: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE6
        s_window_full and (win_code < ibd_pkg::CODE_NEG_FULL_SCALE) |-> win_ones == 9'h000)
        else $error("Below-range window held a one.");

    a_word_taken: assert property (@(posedge i_mod_osc_clk) disable iff (!mrst_n) // RULE2
        req_m && !ack_m |=> code == $past(hold.code))
        else $error("Crossed word differs from the held word.");

endmodule

`default_nettype wire

// *** hw/ibd_pkg.sv ***
// Shared constants and types for the isolated bitstream modulator block.
`default_nettype none

package ibd_pkg;

    // Timing of the system clock and of the start-up interval.
    localparam int REF_PERIOD_NS  = 10;
    localparam int START_TIME_NS  = 500000;
    localparam int START_CYCLES   = (START_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    // Codes are ideal 16-bit offset-binary values: V / 6.4 V * 65536 + 32768.
    localparam int          CODE_W                = 16;
    localparam logic [15:0] FULL_SCALE_LIMIT_CODE = 16'hffff;
    localparam logic [15:0] CODE_REC_TOP          = 16'hd000;
    localparam logic [15:0] CODE_ZERO             = 16'h8000;
    localparam logic [15:0] CODE_NEG_FULL_SCALE   = 16'h7c00;

    // Depth of the buffer in front of the modulator.
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [15:0] code;
    } ibd_word_t;

    typedef enum logic [1:0] {
        IBD_HS_IDLE = 2'b00,
        IBD_HS_REQ  = 2'b01,
        IBD_HS_REL  = 2'b11
    } ibd_hs_t;

endpackage

`default_nettype wire

// *** hw/ibd_sync.sv ***
// Two flip-flop level synchroniser, one chain per bit.
`default_nettype none

module ibd_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         i_clk,
    // Level from another domain
    input  wire logic [W-1:0] i_d,
    // Synchronised level
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk) begin
        meta <= i_d;
        o_q  <= meta;
    end

endmodule

`default_nettype wire

// *** hw/ibd_fifo.sv ***
// Synchronous FIFO with registered ready and valid flags.
`default_nettype none

module ibd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    // Fill side
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    // Drain side
    output logic      [W-1:0] o_data,
    output logic              o_valid,
    input  wire logic         i_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    assign push   = i_valid && o_ready;
    assign pop    = o_valid && i_ready;
    assign o_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + (AW + 1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW + 1)'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    // Flags are registered so that the fill side sees a clean ready.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            count   <= '0;
            o_ready <= 1'b0;
            o_valid <= 1'b0;
        end else begin
            count   <= next_count;
            o_ready <= (next_count != DEPTH_C);
            o_valid <= (next_count != '0);
        end
    end

endmodule

`default_nettype wire

// *** tb/ibd_host_model.sv ***
// Behavioural host decimator that turns the link bit stream into offset-binary words.
`default_nettype none

module ibd_host_model #(
    parameter int RATIO = 256
) (
    // Link pins from the device
    input  wire logic            i_mod_clk,
    input  wire logic            i_mod_data,
    input  wire logic            i_running,
    // Decimated words
    output var ibd_pkg::ibd_word_t o_word,
    output var logic             o_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    int ones;
    int bits;
    int blocks;
    int scaled;

    // A plain ones count stands in for the cubic filter, so only settled densities are exact.
    always @(posedge i_mod_clk or negedge i_running) begin
        if (!i_running) begin
            ones = 0;
            bits = 0;
            blocks = 0;
            o_valid <= 1'b0;
            o_word <= '0;
        end else begin
            ones = ones + int'(i_mod_data);
            bits = bits + 1;
            if (bits == RATIO) begin
                scaled = ones * 65536 / RATIO;
                o_word.code <= (scaled > 65535) ? 16'hffff : 16'(scaled);
                if (blocks < 3) blocks = blocks + 1;
                o_valid <= (blocks == 3);
                ones = 0;
                bits = 0;
            end else begin
                o_valid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/isolated_bitstream_decimator_bench.sv ***
// Self-checking bench for the modulator: start-up, bit clock, densities and buffer.
`default_nettype none

module isolated_bitstream_decimator_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int START = 20;

    logic               i_ref_clk     = 1'b0;
    logic               i_mod_osc_clk = 1'b0;
    logic               i_resetn      = 1'b0;
    logic               i_word_valid  = 1'b0;
    ibd_pkg::ibd_word_t i_word        = '0;
    logic               o_word_ready;
    logic               o_running;
    logic               o_mod_clk;
    logic               o_mod_data;
    logic               host_valid;
    ibd_pkg::ibd_word_t host_word;
    logic               saw_full;
    logic [15:0]        fill_code;
    logic [15:0]        codes [8];
    int                 fails       = 0;
    int                 checks_done = 0;
    int                 cycles      = 0;
    int                 seed        = 32'hea63;
    time                t_rise;

    always #5 i_ref_clk = ~i_ref_clk;
    always #32 i_mod_osc_clk = ~i_mod_osc_clk;

    ibd_modulator #(.START_CYC(START), .DEPTH(ibd_pkg::FIFO_DEPTH)) ibd_modulator_inst (
        .i_ref_clk    (i_ref_clk),
        .i_resetn     (i_resetn),
        .i_mod_osc_clk(i_mod_osc_clk),
        .i_word       (i_word),
        .i_word_valid (i_word_valid),
        .o_word_ready (o_word_ready),
        .o_running    (o_running),
        .o_mod_clk    (o_mod_clk),
        .o_mod_data   (o_mod_data)
    );

    ibd_host_model #(.RATIO(256)) ibd_host_model_inst (
        .i_mod_clk (o_mod_clk),
        .i_mod_data(o_mod_data),
        .i_running (o_running),
        .o_word    (host_word),
        .o_valid   (host_valid)
    );

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Codes used here other than 16'hffff have a zero low byte, so a 256-bit block holds an exact ones count.
    function automatic logic [15:0] exp_code(input logic [15:0] c);
        if (c == 16'hffff) return 16'hffff;
        if (c < ibd_pkg::CODE_NEG_FULL_SCALE) return 16'h0000;
        return c;
    endfunction

    task automatic send(input logic [15:0] c);
        // Calls may start at a host strobe, off the system clock, so line up first.
        @(negedge i_ref_clk);
        for (int k = 0; k < 2000 && o_word_ready !== 1'b1; k++) @(negedge i_ref_clk);
        i_word.code = c;
        i_word_valid = 1'b1;
        @(negedge i_ref_clk);
        i_word_valid = 1'b0;
    endtask

    // The first block after a change may mix both codes, so the second one is judged.
    task automatic measure(input logic [15:0] c);
        repeat (2) @(negedge host_valid);
        check(host_word.code, exp_code(c));
    endtask

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        codes = '{16'h8000, 16'hd000, 16'hffff, 16'h7c00, 16'h0000, 16'h0, 16'h0, 16'h0};
        for (int k = 5; k < 8; k++) codes[k] = {8'h7c + 8'({$random(seed)} % 131), 8'h00};
        fill_code = {8'h80 | 8'($random(seed)), 8'h00};
        // The link side needs several oscillator edges of reset as well.
        repeat (20) @(negedge i_ref_clk);
        repeat (5) @(posedge i_mod_osc_clk);
        @(negedge i_ref_clk);
        check(16'(o_word_ready), 16'h0000);
        check(16'(o_running), 16'h0000);
        check(16'(o_mod_clk), 16'h0000);
        check(16'(o_mod_data), 16'h0000);
        i_resetn = 1'b1;
        repeat (START) @(posedge i_ref_clk);
        #1;
        check(16'(o_running), 16'h0000);
        check(16'(o_word_ready), 16'h0001);
        @(posedge i_ref_clk);
        #1;
        check(16'(o_running), 16'h0001);
        @(posedge o_mod_clk);
        t_rise = $time;
        @(posedge o_mod_clk);
        check(16'(($time - t_rise) / 1ns), 16'h0080);
        for (int k = 0; k < 8; k++) begin
            send(codes[k]);
            measure(codes[k]);
        end
        saw_full = 1'b0;
        repeat (14) begin
            @(negedge i_ref_clk);
            if (o_word_ready !== 1'b1) saw_full = 1'b1;
            i_word.code = (o_word_ready === 1'b1) ? fill_code : 16'h0000;
            i_word_valid = 1'b1;
        end
        @(negedge i_ref_clk);
        i_word_valid = 1'b0;
        check(16'(saw_full), 16'h0001);
        repeat (1000) @(negedge i_ref_clk);
        check(16'(o_word_ready), 16'h0001);
        measure(fill_code);
        wrap_up();
    end
endmodule

`default_nettype wire
